// File: core/dmc_engine.sv
// two-channel transfer engine: demand/block/single data modes, cascade with refresh, status flags
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps

// What this block does
// - demand mode keeps transferring while request held
// - request drop: finish cycle, release bus, suspend
// - count expiry or end-of-process ends buffer
// - buffer start always uses the filtered request, not the sampled one
// - synchronous sampling: request read at final state
// - asynchronous: sample at state start, act at end
// - demand works with single, autoinit, chaining
// - cascade master holds bus while request held
// - refresh during cascade first withdraws acknowledge
// - refresh starts once cascade request removed
// - request present after refresh: direct return
// - chaining flag set when buffer transfer starts
// - chaining flag clears on new parameter write
// - complete flag set; any write to the clear register clears it
// - four flags ORed to irq; status readable
// - 26-bit addresses, 24-bit byte counts
// - overflow limit: only low 16 bits of target address and count change
// - requester/target address inc, dec or hold
// - two-cycle assembling option plus fly-by option
// - legacy config: fly-by, single/autoinit only
// - suspended demand transfer resumes on request
// - autoinit reloads original addresses and count
// - chaining without new parameters goes idle
module dmc_engine
  import dmc_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NCH-1:0]     channel_request,
  output logic      [NCH-1:0]     channel_acknowledge_n,
  input  wire logic               end_of_process_n,
  output logic                    bus_hold_req,
  input  wire logic               bus_hold_gnt,
  output dmc_bus_req_s            bus_req,
  input  wire dmc_bus_rsp_s       bus_rsp,
  input  wire logic               refresh_req,
  output logic                    refresh_active,
  input  wire logic               refresh_done,
  output logic                    transfer_engine_irq
);

  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a, input logic [1:0] am,
                                                  input logic lim);
    logic [ADDR_W-1:0] s;
    s = a;
    if (am == AM_INC)
      s = a + 26'h0000001;
    else if (am == AM_DEC)
      s = a - 26'h0000001;
    // overflow limit keeps the upper address bits fixed
    if (lim)
      s = {a[ADDR_W-1:LIM_W], s[LIM_W-1:0]};
    return s;
  endfunction

  // pin synchronisers: a change counts once stages two and three agree
  logic [NCH:0] sync1;
  logic [NCH:0] sync2;
  logic [NCH:0] sync3;
  logic [NCH:0] filt;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      sync3 <= SYNC_RST;
      filt  <= SYNC_RST;
    end
    else
    begin
      sync1 <= {end_of_process_n, channel_request};
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
    end

  wire logic [NCH-1:0] req_f = filt[NCH-1:0];
  wire logic           eop_f = ~filt[NCH];

  // channel state
  dmc_cfg_s          cfg        [NCH];
  logic [ADDR_W-1:0] base_req   [NCH];
  logic [ADDR_W-1:0] base_tar   [NCH];
  logic [CNT_W-1:0]  base_cnt   [NCH];
  logic [ADDR_W-1:0] cur_req    [NCH];
  logic [ADDR_W-1:0] cur_tar    [NCH];
  logic [CNT_W-1:0]  cur_cnt    [NCH];
  logic [NCH-1:0]    busy;
  logic [NCH-1:0]    started;
  logic [NCH-1:0]    next_valid;
  logic [NCH-1:0]    chain_flag;
  logic [NCH-1:0]    cmpl_flag;

  dmc_state_e        state;
  dmc_state_e        next_state;
  logic              cur;
  logic              next_cur;
  logic [DATA_W-1:0] dat;
  logic              req_smp;
  dmc_bus_req_s      next_bus_req;

  // apb decode; zero wait states
  wire logic [15:0] idx      = paddr[PADDR_W-1:2];
  wire logic        hit_ch   = idx[15:3] == IDX_CH_BASE[15:3];
  wire logic        hit_clr  = idx == IDX_CLR_CMPL;
  wire logic        hit_stat = idx == IDX_STATUS;
  wire logic        wch      = idx[2];
  wire logic [1:0]  fld      = idx[1:0];
  wire logic        acc      = psel & penable;
  wire logic        apb_wr   = acc & pwrite;
  wire logic        wr_ch    = apb_wr & hit_ch;
  wire logic        wr_clr   = apb_wr & hit_clr;

  assign pready  = 1'b1;
  assign pslverr = acc & ~(hit_ch | hit_clr | hit_stat);

  // current channel's effective options
  dmc_cfg_s c;
  assign c = cfg[cur];
  wire logic       eff_two   = c.two_cycle & ~c.legacy;
  wire logic       eff_chain = (c.bmode == BM_CHAIN) & ~c.legacy;
  wire logic       eff_auto  = c.bmode == BM_AUTO;
  wire logic       lim       = c.lim16 | c.legacy;

  wire logic cyc_done = ((state == ST_WR) | (state == ST_FLY)) & bus_rsp.ready;
  wire logic tc       = lim ? (cur_cnt[cur][LIM_W-1:0] == 16'h0000) : (cur_cnt[cur] == 24'h000000);
  wire logic buf_end  = cyc_done & (tc | eop_f);
  wire logic smp_req  = c.async_smp ? req_smp : req_f[cur];
  wire logic cont     = (c.dmode == DM_BLOCK) | ((c.dmode == DM_DEMAND) & smp_req);

  wire logic [ADDR_W-1:0] nxt_req = step_addr(cur_req[cur], c.req_am, 1'b0);
  wire logic [ADDR_W-1:0] nxt_tar = step_addr(cur_tar[cur], c.tar_am, lim);
  wire logic [CNT_W-1:0]  dec_cnt = cur_cnt[cur] - 24'h000001;
  wire logic [CNT_W-1:0]  nxt_cnt = lim ? {cur_cnt[cur][CNT_W-1:LIM_W], dec_cnt[LIM_W-1:0]} : dec_cnt;

  // eligibility; starting a buffer or resuming a suspended one uses the raw filtered request
  logic [NCH-1:0] elig;
  always_comb
    for (int i = 0; i < NCH; i++)
      elig[i] = req_f[i] & (cfg[i].cascade | busy[i]);

  wire logic pick     = ~elig[0];
  wire logic go       = (state == ST_IDLE) & (|elig);
  wire logic start_ev = go & ~cfg[pick].cascade & ~started[pick];

  always_comb
  begin
    next_state = state;
    next_cur   = cur;
    unique case (state)
      ST_IDLE:
        if (go)
        begin
          next_cur   = pick;
          next_state = ST_ARB;
        end
      ST_ARB:
        if (bus_hold_gnt)
          next_state = c.cascade ? ST_CASC : (eff_two ? ST_RD : ST_FLY);
      ST_RD:
        if (bus_rsp.ready)
          next_state = ST_WR;
      ST_WR, ST_FLY:
        if (bus_rsp.ready)
        begin
          // a dropped request finishes this cycle, then gives the bus back
          if (buf_end | ~cont)
            next_state = ST_IDLE;
          else
            next_state = eff_two ? ST_RD : ST_FLY;
        end
      ST_CASC:
        if (!req_f[cur])
          next_state = ST_IDLE;
        else if (refresh_req)
          next_state = ST_CASC_DROP;
      ST_CASC_DROP:
        if (!req_f[cur])
          next_state = ST_REFR;
      ST_REFR:
        if (refresh_done)
          next_state = req_f[cur] ? ST_CASC : ST_IDLE;
    endcase
  end

  // next bus request; addresses already stepped when a cycle just finished
  wire logic [ADDR_W-1:0] ra = cyc_done ? nxt_req : cur_req[cur];
  wire logic [ADDR_W-1:0] ta = cyc_done ? nxt_tar : cur_tar[cur];
  wire logic [DATA_W-1:0] rd_dat = (state == ST_RD) ? bus_rsp.rdata : dat;

  always_comb
  begin
    next_bus_req = BUS_REQ_RST;
    unique case (next_state)
      ST_RD:
        next_bus_req = '{valid: 1'b1, write: 1'b0, io: c.req_io | c.legacy, addr: ra, wdata: '0};
      ST_WR:
        next_bus_req = '{valid: 1'b1, write: 1'b1, io: 1'b0, addr: ta, wdata: rd_dat};
      ST_FLY:
        next_bus_req = '{valid: 1'b1, write: c.fly_wr, io: 1'b0, addr: ta, wdata: '0};
      default:
        next_bus_req = BUS_REQ_RST;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state   <= ST_IDLE;
      cur     <= 1'b0;
      dat     <= '0;
      req_smp <= 1'b0;
      bus_req <= BUS_REQ_RST;
    end
    else
    begin
      state   <= next_state;
      cur     <= next_cur;
      bus_req <= next_bus_req;
      if (state == ST_RD && bus_rsp.ready)
        dat <= bus_rsp.rdata;
      // caught as a state begins, acted upon when it ends
      if (next_state != state || cyc_done)
        req_smp <= req_f[next_cur];
    end

  // handshake outputs straight from the state flops
  always_comb
    for (int i = 0; i < NCH; i++)
      channel_acknowledge_n[i] = ~((cur == i) & ((state == ST_RD) | (state == ST_WR) |
                                   (state == ST_FLY) | (state == ST_CASC)));
  assign bus_hold_req   = state != ST_IDLE;
  assign refresh_active = state == ST_REFR;

  // per-channel register file and buffer-transfer mode handling
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        cfg[i]      <= CFG_RST;
        base_req[i] <= '0;
        base_tar[i] <= '0;
        base_cnt[i] <= '0;
        cur_req[i]  <= '0;
        cur_tar[i]  <= '0;
        cur_cnt[i]  <= '0;
      end
      busy       <= '0;
      started    <= '0;
      next_valid <= '0;
      chain_flag <= '0;
      cmpl_flag  <= '0;
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (cyc_done && cur == i)
        begin
          cur_req[i] <= nxt_req;
          cur_tar[i] <= nxt_tar;
          cur_cnt[i] <= nxt_cnt;
        end
        if (buf_end && cur == i)
        begin
          started[i] <= 1'b0;
          if (eff_auto || (eff_chain && next_valid[i]))
          begin
            cur_req[i]    <= base_req[i];
            cur_tar[i]    <= base_tar[i];
            cur_cnt[i]    <= base_cnt[i];
            next_valid[i] <= 1'b0;
          end
          else
            busy[i] <= 1'b0;
        end
        if (start_ev && pick == i)
          started[i] <= 1'b1;
        // an idle channel loads base and working copy; a busy one only the base
        if (wr_ch && wch == i)
        begin
          unique case (fld)
            FLD_CFG:
              if (!busy[i])
                cfg[i] <= pwdata[CFG_W-1:0];
            FLD_REQA:
            begin
              base_req[i] <= pwdata[ADDR_W-1:0];
              if (!busy[i])
                cur_req[i] <= pwdata[ADDR_W-1:0];
            end
            FLD_TARA:
            begin
              base_tar[i] <= pwdata[ADDR_W-1:0];
              if (!busy[i])
                cur_tar[i] <= pwdata[ADDR_W-1:0];
            end
            FLD_CNT:
            begin
              base_cnt[i] <= pwdata[CNT_W-1:0];
              if (!busy[i])
              begin
                cur_cnt[i] <= pwdata[CNT_W-1:0];
                busy[i]    <= ~cfg[i].cascade;
              end
              else
                next_valid[i] <= 1'b1;
            end
          endcase
        end
      end
      // hardware set wins over a clear in the same cycle
      for (int i = 0; i < NCH; i++)
      begin
        chain_flag[i] <= ((start_ev && pick == i) && (cfg[i].bmode == BM_CHAIN) && !cfg[i].legacy) |
                         (chain_flag[i] & ~(wr_ch && wch == i && fld == FLD_CNT && busy[i]));
        cmpl_flag[i]  <= (buf_end && cur == i) | (cmpl_flag[i] & ~wr_clr);
      end
    end

  assign transfer_engine_irq = |{chain_flag, cmpl_flag};

  // read data captured in the setup phase, presented in the access phase
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    if (hit_stat)
    begin
      rd_mux[ST_CMPL_LSB +: NCH]  = cmpl_flag;
      rd_mux[ST_CHAIN_LSB +: NCH] = chain_flag;
      rd_mux[ST_BUSY_LSB +: NCH]  = busy;
    end
    else if (hit_ch)
    begin
      unique case (fld)
        FLD_CFG:  rd_mux[CFG_W-1:0]  = cfg[wch];
        FLD_REQA: rd_mux[ADDR_W-1:0] = cur_req[wch];
        FLD_TARA: rd_mux[ADDR_W-1:0] = cur_tar[wch];
        FLD_CNT:  rd_mux[CNT_W-1:0]  = cur_cnt[wch];
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable)
      prdata <= rd_mux;

  // checks
  property p_demand_cont;
    @(posedge pclk) disable iff (!presetn)
    (cyc_done && !buf_end && c.dmode == DM_DEMAND && smp_req) |=> (state == ST_RD || state == ST_FLY) && bus_hold_req;
  endproperty
  a_demand_cont: assert property (p_demand_cont) else $error("demand transfer stopped with request held");

  property p_demand_stop;
    @(posedge pclk) disable iff (!presetn)
    (cyc_done && !buf_end && c.dmode == DM_DEMAND && !smp_req) |=> state == ST_IDLE && !bus_hold_req;
  endproperty
  a_demand_stop: assert property (p_demand_stop) else $error("bus kept after request dropped");

  property p_end_flag;
    @(posedge pclk) disable iff (!presetn)
    buf_end |=> cmpl_flag[$past(cur)] && state == ST_IDLE;
  endproperty
  a_end_flag: assert property (p_end_flag) else $error("complete flag missing after buffer end");

  property p_clr;
    @(posedge pclk) disable iff (!presetn)
    (wr_clr && !buf_end) |=> cmpl_flag == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("complete flag not cleared by write");

  property p_ref_drop;
    @(posedge pclk) disable iff (!presetn)
    (state == ST_CASC && req_f[cur] && refresh_req) |=> channel_acknowledge_n[cur] && !refresh_active;
  endproperty
  a_ref_drop: assert property (p_ref_drop) else $error("acknowledge kept during refresh request");

  property p_ref_start;
    @(posedge pclk) disable iff (!presetn)
    (state == ST_CASC_DROP && !req_f[cur]) |=> refresh_active;
  endproperty
  a_ref_start: assert property (p_ref_start) else $error("refresh not started after request removal");

  property p_ref_return;
    @(posedge pclk) disable iff (!presetn)
    (state == ST_REFR && refresh_done && req_f[cur]) |=> !channel_acknowledge_n[$past(cur)] && state == ST_CASC;
  endproperty
  a_ref_return: assert property (p_ref_return) else $error("bus not returned to cascaded master");

  property p_chain_set;
    @(posedge pclk) disable iff (!presetn)
    (start_ev && cfg[pick].bmode == BM_CHAIN && !cfg[pick].legacy) |=> chain_flag[$past(pick)] && transfer_engine_irq;
  endproperty
  a_chain_set: assert property (p_chain_set) else $error("chaining flag not raised at start");

  property p_lim16;
    @(posedge pclk) disable iff (!presetn)
    (cyc_done && lim && !buf_end) |=> cur_cnt[cur][CNT_W-1:LIM_W] == $past(cur_cnt[cur][CNT_W-1:LIM_W]);
  endproperty
  a_lim16: assert property (p_lim16) else $error("upper count bits changed under limit");

endmodule

// File: dv/dmc_bus_model.sv
// system bus partner: grants the bus and answers each engine bus cycle after a latency
`timescale 1ns/100ps
module dmc_bus_model
  import dmc_pkg::*;
#(
  parameter int LAT = 3
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         bus_hold_req,
  output logic              bus_hold_gnt,
  input  wire dmc_bus_req_s bus_req,
  output dmc_bus_rsp_s      bus_rsp
);
  logic [7:0] wait_cnt;
  logic [7:0] noise;
  logic       rdy;
  // data only valid with ready; a moving pattern otherwise so stale data never looks right
  assign bus_rsp.ready = rdy;
  assign bus_rsp.rdata = rdy ? ~bus_req.addr[7:0] : noise;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_hold_gnt <= 1'b0;
      wait_cnt     <= 8'h00;
      noise        <= 8'h00;
      rdy          <= 1'b0;
    end
    else
    begin
      bus_hold_gnt <= bus_hold_req;
      noise        <= noise + 8'h5B;
      rdy          <= 1'b0;
      if (bus_req.valid && !rdy && wait_cnt == 8'(LAT))
      begin
        rdy      <= 1'b1;
        wait_cnt <= 8'h00;
      end
      else if (bus_req.valid && !rdy)
        wait_cnt <= wait_cnt + 8'h01;
      else
        wait_cnt <= 8'h00;
    end
  end
endmodule

// File: dv/tb.sv
// self-checking bench for the transfer engine: registers, demand, chaining, cascade, 16-bit limit
`timescale 1ns/100ps
module tb;
  import dmc_pkg::*;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [PADDR_W-1:0] paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [NCH-1:0]     channel_request;
  logic [NCH-1:0]     channel_acknowledge_n;
  logic               end_of_process_n;
  logic               bus_hold_req;
  logic               bus_hold_gnt;
  dmc_bus_req_s       bus_req;
  dmc_bus_rsp_s       bus_rsp;
  logic               refresh_req;
  logic               refresh_active;
  logic               refresh_done;
  logic               transfer_engine_irq;
  int                 failures;
  int                 checked;
  int                 cycles;
  int                 xfers;
  logic [31:0]        rv;
  logic               er;

  dmc_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_request(channel_request), .channel_acknowledge_n(channel_acknowledge_n),
    .end_of_process_n(end_of_process_n), .bus_hold_req(bus_hold_req), .bus_hold_gnt(bus_hold_gnt),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .refresh_req(refresh_req), .refresh_active(refresh_active),
    .refresh_done(refresh_done), .transfer_engine_irq(transfer_engine_irq));
  dmc_bus_model #(.LAT(3)) partner (.pclk(pclk), .presetn(presetn), .bus_hold_req(bus_hold_req),
    .bus_hold_gnt(bus_hold_gnt), .bus_req(bus_req), .bus_rsp(bus_rsp));

  always #2 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (bus_req.valid && bus_rsp.ready)
      xfers++;
    // a hang anywhere ends here instead of running forever
    if (cycles == 40000)
    begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= PADDR_W'({idx, 2'b00});
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [15:0] chx(input int ch, input logic [1:0] f);
    return IDX_CH_BASE + 16'(4 * ch) + 16'(f);
  endfunction

  task automatic setup(input int ch, input dmc_bmode_e b, input dmc_amode_e am, input logic asy,
                       input logic casc, input logic lim, input logic [31:0] tar, input logic [31:0] cnt);
    dmc_cfg_s c;
    c = '0;
    c.dmode = DM_DEMAND;
    c.bmode = b;
    c.tar_am = am;
    c.async_smp = asy;
    c.cascade = casc;
    c.lim16 = lim;
    c.fly_wr = 1'b1;
    apb(1'b1, chx(ch, FLD_CFG), 32'(c));
    apb(1'b1, chx(ch, FLD_TARA), tar);
    xfers = 0;
    apb(1'b1, chx(ch, FLD_CNT), cnt);
  endtask

  // poll status until the channel is no longer busy
  task automatic wait_idle(input int ch);
    for (int i = 0; i < 300; i++)
    begin
      apb(1'b0, IDX_STATUS, 32'h0);
      if (rv[ST_BUSY_LSB + ch] === 1'b0)
        break;
    end
  endtask

  task automatic t_reset();
    @(negedge pclk);
    check("ack_n", 32'(channel_acknowledge_n), 32'h3);
    check("irq", 32'(transfer_engine_irq), 32'h0);
    check("hold", 32'({bus_hold_req, refresh_active}), 32'h0);
    apb(1'b0, IDX_STATUS, 32'h0);
    check("status", rv, 32'h0);
    apb(1'b0, IDX_CLR_CMPL, 32'h0);
    check("clear_rd", rv, 32'h0);
    apb(1'b0, 16'h0000, 32'h0);
    check("unmapped_err", 32'(er), 32'h1);
    $display("test reset done");
  endtask

  task automatic t_demand_full();
    setup(0, BM_SINGLE, AM_INC, 1'b0, 1'b0, 1'b0, 32'h100, 32'h3);
    channel_request[0] <= 1'b1;
    wait_idle(0);
    check("xfers", 32'(xfers), 32'h4);
    apb(1'b0, chx(0, FLD_TARA), 32'h0);
    check("tar", rv, 32'h104);
    apb(1'b0, IDX_STATUS, 32'h0);
    check("cmpl", 32'(rv[ST_CMPL_LSB]), 32'h1);
    check("irq", 32'(transfer_engine_irq), 32'h1);
    channel_request[0] <= 1'b0;
    apb(1'b1, IDX_CLR_CMPL, 32'h5A);
    apb(1'b0, IDX_STATUS, 32'h0);
    check("cmpl_clr", 32'(rv[1:0]), 32'h0);
    check("irq_clr", 32'(transfer_engine_irq), 32'h0);
    $display("test demand full done");
  endtask

  // request dropped mid-buffer, held off, then restored; both sampling modes
  task automatic t_suspend();
    int seen;
    for (int m = 0; m < 2; m++)
    begin
      setup(0, BM_SINGLE, AM_DEC, m[0], 1'b0, 1'b0, 32'h800, 32'h9);
      channel_request[0] <= 1'b1;
      repeat (24) @(posedge pclk);
      channel_request[0] <= 1'b0;
      repeat (24) @(negedge pclk);
      seen = xfers;
      check("released", 32'(bus_hold_req), 32'h0);
      check("partial", 32'(seen < 10 && seen > 0), 32'h1);
      repeat (24) @(negedge pclk);
      check("held_off", 32'(xfers), 32'(seen));
      @(posedge pclk);
      channel_request[0] <= 1'b1;
      wait_idle(0);
      check("resumed", 32'(xfers), 32'hA);
      apb(1'b0, chx(0, FLD_TARA), 32'h0);
      check("tar_dec", rv, 32'h7F6);
      channel_request[0] <= 1'b0;
      apb(1'b1, IDX_CLR_CMPL, 32'h0);
    end
    $display("test suspend done");
  endtask

  task automatic t_chain();
    setup(1, BM_CHAIN, AM_INC, 1'b0, 1'b0, 1'b0, 32'h200, 32'h5);
    channel_request[1] <= 1'b1;
    repeat (12) @(posedge pclk);
    apb(1'b0, IDX_STATUS, 32'h0);
    check("chain_set", 32'(rv[ST_CHAIN_LSB + 1]), 32'h1);
    apb(1'b1, chx(1, FLD_TARA), 32'h300);
    apb(1'b1, chx(1, FLD_CNT), 32'h2);
    apb(1'b0, IDX_STATUS, 32'h0);
    check("chain_clr", 32'(rv[ST_CHAIN_LSB + 1]), 32'h0);
    wait_idle(1);
    check("chained_xfers", 32'(xfers), 32'h9);
    apb(1'b0, chx(1, FLD_TARA), 32'h0);
    check("tar_new", rv, 32'h303);
    channel_request[1] <= 1'b0;
    apb(1'b1, IDX_CLR_CMPL, 32'h0);
    $display("test chaining done");
  endtask

  task automatic t_cascade();
    int i;
    setup(1, BM_SINGLE, AM_INC, 1'b0, 1'b1, 1'b0, 32'h0, 32'h0);
    channel_request[1] <= 1'b1;
    for (i = 0; i < 20 && channel_acknowledge_n[1] !== 1'b0; i++)
      @(negedge pclk);
    repeat (6) @(negedge pclk);
    check("casc_ack", 32'(channel_acknowledge_n[1]), 32'h0);
    @(posedge pclk);
    refresh_req <= 1'b1;
    repeat (3) @(negedge pclk);
    check("ack_drop", 32'(channel_acknowledge_n[1]), 32'h1);
    check("no_refr_yet", 32'(refresh_active), 32'h0);
    @(posedge pclk);
    channel_request[1] <= 1'b0;
    for (i = 0; i < 10 && refresh_active !== 1'b1; i++)
      @(negedge pclk);
    check("refr_start", 32'(refresh_active), 32'h1);
    @(posedge pclk);
    refresh_req <= 1'b0;
    channel_request[1] <= 1'b1;
    repeat (8) @(posedge pclk);
    refresh_done <= 1'b1;
    @(posedge pclk);
    refresh_done <= 1'b0;
    repeat (2) @(negedge pclk);
    check("ack_back", 32'(channel_acknowledge_n[1]), 32'h0);
    check("refr_end", 32'(refresh_active), 32'h0);
    @(posedge pclk);
    channel_request[1] <= 1'b0;
    repeat (10) @(negedge pclk);
    check("casc_end", 32'(channel_acknowledge_n[1]), 32'h1);
    $display("test cascade done");
  endtask

  // low 16 bits only: count 0x0001 runs 2 bytes, address wraps within the low half
  task automatic t_lim16();
    setup(0, BM_SINGLE, AM_INC, 1'b0, 1'b0, 1'b1, 32'h2FFFF, 32'h120001);
    channel_request[0] <= 1'b1;
    wait_idle(0);
    check("lim_xfers", 32'(xfers), 32'h2);
    apb(1'b0, chx(0, FLD_TARA), 32'h0);
    check("lim_tar", rv, 32'h20001);
    apb(1'b0, chx(0, FLD_CNT), 32'h0);
    check("lim_cnt", rv, 32'h12FFFF);
    channel_request[0] <= 1'b0;
    $display("test limit16 done");
  endtask

  // end-of-process cuts an autoinit buffer short; the channel reloads and waits for its request
  task automatic t_eop_auto();
    apb(1'b1, IDX_CLR_CMPL, 32'h0);
    setup(0, BM_AUTO, AM_INC, 1'b0, 1'b0, 1'b0, 32'h40, 32'h7);
    channel_request[0] <= 1'b1;
    repeat (14) @(posedge pclk);
    channel_request[0] <= 1'b0;
    end_of_process_n <= 1'b0;
    repeat (20) @(posedge pclk);
    end_of_process_n <= 1'b1;
    check("eop_xfers", 32'(xfers > 0 && xfers < 8), 32'h1);
    apb(1'b0, chx(0, FLD_TARA), 32'h0);
    check("auto_tar", rv, 32'h40);
    apb(1'b0, chx(0, FLD_CNT), 32'h0);
    check("auto_cnt", rv, 32'h7);
    apb(1'b0, IDX_STATUS, 32'h0);
    check("eop_cmpl", 32'({rv[ST_BUSY_LSB], rv[ST_CMPL_LSB]}), 32'h3);
    $display("test end of process done");
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    channel_request = '0;
    end_of_process_n = 1'b1;
    refresh_req = 1'b0;
    refresh_done = 1'b0;
    failures = 0;
    checked = 0;
    cycles = 0;
    xfers = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_demand_full();
    t_suspend();
    t_chain();
    t_cascade();
    t_lim16();
    t_eop_auto();
    end_sim();
  end
endmodule

// File: pkg/dmc_pkg.sv
// constants, types and register layout of the two-channel demand/cascade transfer engine
package dmc_pkg;

  localparam int NCH    = 2;
  localparam int ADDR_W = 26;
  localparam int CNT_W  = 24;
  localparam int LIM_W  = 16;
  localparam int DATA_W = 8;
  localparam int PADDR_W = 18;
  localparam int SYNC_STAGES = 3;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CLR_CMPL = 16'hF01E;
  localparam logic [15:0] IDX_STATUS   = 16'hF020;
  localparam logic [15:0] IDX_CH_BASE  = 16'hF040;
  localparam logic [1:0]  FLD_CFG      = 2'h0;
  localparam logic [1:0]  FLD_REQA     = 2'h1;
  localparam logic [1:0]  FLD_TARA     = 2'h2;
  localparam logic [1:0]  FLD_CNT      = 2'h3;

  // status register bit positions
  localparam int ST_CMPL_LSB  = 0;
  localparam int ST_CHAIN_LSB = 2;
  localparam int ST_BUSY_LSB  = 4;

  localparam logic [2:0] SYNC_RST = 3'h4;

  typedef enum logic [1:0] {DM_SINGLE = 2'b00, DM_BLOCK = 2'b01, DM_DEMAND = 2'b10} dmc_dmode_e;
  typedef enum logic [1:0] {BM_SINGLE = 2'b00, BM_AUTO = 2'b01, BM_CHAIN = 2'b10} dmc_bmode_e;
  typedef enum logic [1:0] {AM_INC = 2'b00, AM_DEC = 2'b01, AM_HOLD = 2'b10} dmc_amode_e;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_ARB       = 3'b001,
    ST_RD        = 3'b010,
    ST_WR        = 3'b011,
    ST_FLY       = 3'b100,
    ST_CASC      = 3'b101,
    ST_CASC_DROP = 3'b110,
    ST_REFR      = 3'b111
  } dmc_state_e;

  // channel configuration word, bit 0 = dmode[0]
  typedef struct packed {
    logic       legacy;
    logic       lim16;
    logic       req_io;
    logic       fly_wr;
    logic       two_cycle;
    logic       cascade;
    logic       async_smp;
    logic [1:0] tar_am;
    logic [1:0] req_am;
    logic [1:0] bmode;
    logic [1:0] dmode;
  } dmc_cfg_s;

  localparam int CFG_W = 15;
  localparam logic [CFG_W-1:0] CFG_RST = 15'h0000;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              io;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dmc_bus_req_s;

  typedef struct packed {
    logic              ready;
    logic [DATA_W-1:0] rdata;
  } dmc_bus_rsp_s;

  localparam dmc_bus_req_s BUS_REQ_RST = '0;

endpackage
